// >>> hdl/sgp_consts.vh
`ifndef SGP_CONSTS_VH
`define SGP_CONSTS_VH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define SGP_OFS_PORT_DATA    12'h000
`define SGP_OFS_LATCH        12'h004
`define SGP_OFS_DIRECTION    12'h008
`define SGP_OFS_ANALOG       12'h00C
`define SGP_OFS_THRESHOLD    12'h010
`define SGP_OFS_PULLUP       12'h014
`define SGP_OFS_OPTION       12'h018

// ----------------------------------------------------------------
// Field layout
// ----------------------------------------------------------------
`define SGP_PIN_MSB          5
`define SGP_PIN_THREE        3
`define SGP_OPT_PUDIS_BIT    7

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define SGP_RST_LATCH        6'h00
`define SGP_RST_DIRECTION    6'h3F
`define SGP_RST_ANALOG       6'h3F
`define SGP_RST_THRESHOLD    6'h00
`define SGP_RST_PULLUP       6'h3F
`define SGP_RST_PUDIS        1'b1

`endif

// >>> hdl/sgp_pin_cell.v
`timescale 1ns/10ps
// One pad slice: driver, pull-up, input qualification and synchroniser
module sgp_pin_cell
(
    // Clock and reset
    input  wire pclk,
    input  wire presetn,
    // Configuration
    input  wire dir_in,
    input  wire latch_val,
    input  wire analog_sel,
    input  wire ttl_sel,
    input  wire pullup_en,
    input  wire pullup_gdis,
    // Pad side
    input  wire pad_schmitt_in,
    input  wire pad_ttl_in,
    // Results
    output wire pad_out,
    output wire pad_oe,
    output wire pad_pullup,
    output wire level
);

    reg  schm1_ff;
    reg  schm2_ff;
    reg  ttl1_ff;
    reg  ttl2_ff;
    wire sel_in;
    reg oe_ff;
    reg out_ff;
    reg pu_ff;

    // ----------------------------------------------------------------
    // Input synchronisers
    // ----------------------------------------------------------------
    // Both receivers are synchronised before the select, so no logic
    // sees a raw pad; a threshold change can still show a false edge
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            schm1_ff <= 1'b0;
            schm2_ff <= 1'b0;
            ttl1_ff  <= 1'b0;
            ttl2_ff  <= 1'b0;
        end
        else
        begin
            schm1_ff <= pad_schmitt_in;
            schm2_ff <= schm1_ff;
            ttl1_ff  <= pad_ttl_in;
            ttl2_ff  <= ttl1_ff;
        end
    end

    // Chosen receiver feeds the reads
    assign sel_in = ttl_sel ? ttl2_ff : schm2_ff;

    // Analog pins read as zero; the receiver is left out of the path
    assign level = sel_in & ~analog_sel;

    // ----------------------------------------------------------------
    // Driver and pull-up, registered so pad outputs never glitch
    // ----------------------------------------------------------------
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            oe_ff  <= 1'b0;
            out_ff <= 1'b0;
            pu_ff  <= 1'b0;
        end
        else
        begin
            oe_ff  <= ~dir_in;
            out_ff <= latch_val;
            pu_ff  <= pullup_en & dir_in & ~pullup_gdis;
        end
    end

    assign pad_oe     = oe_ff;
    assign pad_out    = out_ff;
    assign pad_pullup = pu_ff;

endmodule

// >>> hdl/sgp_gpio_port.v
`timescale 1ns/10ps
`include "sgp_consts.vh"

module sgp_gpio_port
(
    // APB slave
    input  wire        pclk,
    input  wire        presetn,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    input  wire [3:0]  pstrb,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    // Pad receivers
    input  wire [5:0]  pad_schmitt_in,
    input  wire [5:0]  pad_ttl_in,
    // Pad controls
    output wire [5:0]  pad_out,
    output wire [5:0]  pad_oe,
    output wire [5:0]  pad_pullup,
    output reg  [5:0]  analog_enable
);

    // ----------------------------------------------------------------
    // Configuration storage
    // ----------------------------------------------------------------
    reg  [5:0]  latch_ff;
    reg  [5:0]  dir_ff;
    reg  [5:0]  analog_ff;
    reg  [5:0]  thresh_ff;
    reg  [5:0]  pullup_ff;
    reg         pudis_ff;

    reg  [5:0]  nxt_latch;
    reg  [5:0]  nxt_dir;
    reg  [5:0]  nxt_analog;
    reg  [5:0]  nxt_thresh;
    reg  [5:0]  nxt_pullup;
    reg         nxt_pudis;
    reg  [31:0] nxt_prdata;
    reg         nxt_pslverr;

    wire [5:0]  pin_level;
    wire [5:0]  dir_eff;

    // ----------------------------------------------------------------
    // Bus phase decode
    // ----------------------------------------------------------------
    // First access cycle: ready is raised here, so one wait state always
    wire        access   = psel & penable & ~pready;
    // Completing edge, the one at which the master sees ready high
    wire        complete = psel & penable & pready;
    // Writes land only at completion; lane 0 carries every bit
    wire        wr_en    = complete & pwrite & pstrb[0];
    wire [7:0]  wbyte    = pwdata[7:0];

    // ----------------------------------------------------------------
    // Address decode, one select per register
    // ----------------------------------------------------------------
    // Unmapped offsets select nothing, so a stray write changes no state
    wire        sel_port   = (paddr == `SGP_OFS_PORT_DATA);
    wire        sel_latch  = (paddr == `SGP_OFS_LATCH);
    wire        sel_dir    = (paddr == `SGP_OFS_DIRECTION);
    wire        sel_analog = (paddr == `SGP_OFS_ANALOG);
    wire        sel_thresh = (paddr == `SGP_OFS_THRESHOLD);
    wire        sel_pullup = (paddr == `SGP_OFS_PULLUP);
    wire        sel_option = (paddr == `SGP_OFS_OPTION);

    // Write strobes, at most one high in any cycle
    wire        wr_port    = wr_en & sel_port;
    wire        wr_latch   = wr_en & sel_latch;
    wire        wr_dir     = wr_en & sel_dir;
    wire        wr_analog  = wr_en & sel_analog;
    wire        wr_thresh  = wr_en & sel_thresh;
    wire        wr_pullup  = wr_en & sel_pullup;
    wire        wr_option  = wr_en & sel_option;

    // Pin three can never drive, whatever software stored
    assign dir_eff = dir_ff | (6'h01 << `SGP_PIN_THREE);

    // ----------------------------------------------------------------
    // Per-pin pad slices
    // ----------------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi <= `SGP_PIN_MSB; gi = gi + 1)
        begin : g_pin
            sgp_pin_cell u_cell
            (
                .pclk           (pclk),
                .presetn        (presetn),
                .dir_in         (dir_eff[gi]),
                .latch_val      (latch_ff[gi]),
                .analog_sel     (analog_ff[gi]),
                .ttl_sel        (thresh_ff[gi]),
                .pullup_en      (pullup_ff[gi]),
                .pullup_gdis    (pudis_ff),
                .pad_schmitt_in (pad_schmitt_in[gi]),
                .pad_ttl_in     (pad_ttl_in[gi]),
                .pad_out        (pad_out[gi]),
                .pad_oe         (pad_oe[gi]),
                .pad_pullup     (pad_pullup[gi]),
                .level          (pin_level[gi])
            );
        end
    endgenerate

    // ----------------------------------------------------------------
    // Next values of the configuration registers
    // ----------------------------------------------------------------
    // Port data write: pins are read and the written bits merged in.
    // All six bits come from the bus, so no sampled level survives;
    // an analog pin reading zero cannot leak into its latch this way.
    always @*
    begin
        nxt_latch = latch_ff;
        if (wr_port)
        begin
            nxt_latch = (pin_level & ~6'h3F) | wbyte[5:0];
        end
        else if (wr_latch)
        begin
            nxt_latch = wbyte[5:0];
        end
    end

    // Direction bits; pin three is forced on the read and driver side
    always @*
    begin
        nxt_dir = dir_ff;
        if (wr_dir)
        begin
            nxt_dir = wbyte[5:0];
        end
    end

    // Analog select
    always @*
    begin
        nxt_analog = analog_ff;
        if (wr_analog)
        begin
            nxt_analog = wbyte[5:0];
        end
    end

    // Threshold select: 1 picks the TTL receiver
    always @*
    begin
        nxt_thresh = thresh_ff;
        if (wr_thresh)
        begin
            nxt_thresh = wbyte[5:0];
        end
    end

    // Pull-up enables
    always @*
    begin
        nxt_pullup = pullup_ff;
        if (wr_pullup)
        begin
            nxt_pullup = wbyte[5:0];
        end
    end

    // Global pull-up disable in the option word
    always @*
    begin
        nxt_pudis = pudis_ff;
        if (wr_option)
        begin
            nxt_pudis = wbyte[`SGP_OPT_PUDIS_BIT];
        end
    end

    // ----------------------------------------------------------------
    // Read mux and error answer, taken in the first access cycle
    // ----------------------------------------------------------------
    always @*
    begin
        nxt_prdata  = 32'h0000_0000;
        nxt_pslverr = 1'b0;
        case (paddr)
            `SGP_OFS_PORT_DATA: nxt_prdata = {26'h0, pin_level};
            `SGP_OFS_LATCH:     nxt_prdata = {26'h0, latch_ff};
            `SGP_OFS_DIRECTION: nxt_prdata = {26'h0, dir_eff};
            `SGP_OFS_ANALOG:    nxt_prdata = {26'h0, analog_ff};
            `SGP_OFS_THRESHOLD: nxt_prdata = {26'h0, thresh_ff};
            `SGP_OFS_PULLUP:    nxt_prdata = {26'h0, pullup_ff};
            `SGP_OFS_OPTION:    nxt_prdata = {24'h0, pudis_ff, 7'h00};
            default:            nxt_pslverr = 1'b1;
        endcase
    end

    // ----------------------------------------------------------------
    // Configuration registers
    // ----------------------------------------------------------------
    // Output latch, cleared so a pin later made an output starts low
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            latch_ff <= `SGP_RST_LATCH;
        end
        else
        begin
            latch_ff <= nxt_latch;
        end
    end

    // Direction, all inputs after reset so no driver fights the board
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            dir_ff <= `SGP_RST_DIRECTION;
        end
        else
        begin
            dir_ff <= nxt_dir;
        end
    end

    // Analog select and its copy on the pin side
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            analog_ff     <= `SGP_RST_ANALOG;
            analog_enable <= `SGP_RST_ANALOG;
        end
        else
        begin
            analog_ff     <= nxt_analog;
            analog_enable <= nxt_analog;
        end
    end

    // Threshold select
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            thresh_ff <= `SGP_RST_THRESHOLD;
        end
        else
        begin
            thresh_ff <= nxt_thresh;
        end
    end

    // Pull-up enables
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pullup_ff <= `SGP_RST_PULLUP;
        end
        else
        begin
            pullup_ff <= nxt_pullup;
        end
    end

    // Global disable, set by reset so no pull-up acts before software
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pudis_ff <= `SGP_RST_PUDIS;
        end
        else
        begin
            pudis_ff <= nxt_pudis;
        end
    end

    // ----------------------------------------------------------------
    // Bus answer
    // ----------------------------------------------------------------
    // Data and error are loaded together with ready and cleared after
    // it, so they never stand outside the one completing cycle
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata  <= 32'h0000_0000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end
        else
        begin
            pready <= access;
            if (access)
            begin
                prdata  <= pwrite ? 32'h0000_0000 : nxt_prdata;
                pslverr <= nxt_pslverr;
            end
            else
            begin
                prdata  <= 32'h0000_0000;
                pslverr <= 1'b0;
            end
        end
    end

endmodule

// >>> testbench/sgp_pads.sv
`timescale 1ns/10ps
// Board circuitry on the six pads
module sgp_pads
(
    // Pad controls
    input  wire [5:0] pad_out,
    input  wire [5:0] pad_oe,
    // Board levels
    input  wire [5:0] ext_val,
    input  wire [5:0] mid_lvl,
    // Receivers
    output wire [5:0] pad_schmitt_in,
    output wire [5:0] pad_ttl_in
);
    // Driver beats the board; a mid level splits the two receivers
    assign pad_schmitt_in = (pad_oe & pad_out) | (~pad_oe & ext_val & ~mid_lvl);
    assign pad_ttl_in     = (pad_oe & pad_out) | (~pad_oe & (ext_val | mid_lvl));
endmodule

// >>> testbench/sgp_gpio_port_chk.sv
`timescale 1ns/10ps
module sgp_gpio_port_chk
(
    // Bus
    input wire        pclk,
    input wire        presetn,
    input wire        psel,
    input wire        penable,
    input wire        pwrite,
    input wire [11:0] paddr,
    input wire [31:0] prdata,
    input wire        pready,
    input wire        pslverr,
    // Pads
    input wire [5:0]  pad_oe,
    input wire [5:0]  pad_pullup,
    input wire [5:0]  analog_enable
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // ----------------
    // Transfer phases
    // ----------------
    sequence setup_s; psel && !penable; endsequence
    sequence access_s; psel && penable; endsequence
    wire rd_done = pready && psel && penable && !pwrite;
    one_wait_a: assert property (setup_s ##1 access_s |=> pready) else $error("ready late");
    ready_pulse_a: assert property (pready |=> !pready) else $error("ready held");
    err_pair_a: assert property (pslverr |-> pready && psel && penable) else $error("stray error");
    idle_data_a: assert property (!pready |-> prdata == 32'h0) else $error("data idle");
    pull_off_a: assert property ((pad_oe & pad_pullup) == 6'h00) else $error("pull on out");
    pin_three_a: assert property (!pad_oe[3]) else $error("pin three drives");
    dir_read_a: assert property (rd_done && paddr == 12'h008 |->
        prdata[7:6] == 2'h0 && prdata[3]) else $error("direction bits");
    analog_zero_a: assert property (rd_done && paddr == 12'h000 |->
        (prdata[5:0] & analog_enable) == 6'h00) else $error("analog read");
endmodule
bind sgp_gpio_port sgp_gpio_port_chk u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .pad_oe(pad_oe), .pad_pullup(pad_pullup), .analog_enable(analog_enable));

// >>> testbench/tb_sgp_gpio_port.sv
`timescale 1ns/10ps
module tb_sgp_gpio_port;
    // ----------------
    // Stimulus and model state
    // ----------------
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [3:0]  pstrb = 4'h0;
    logic [5:0]  ext_val = 6'h00;
    logic [5:0]  mid_lvl = 6'h00;
    logic [31:0] rdat;
    logic        rerr;
    wire  [31:0] prdata;
    wire         pready;
    wire         pslverr;
    wire  [5:0]  sch_in, ttl_in, pad_out, pad_oe, pad_pu, ana_en;
    int          err_count = 0;
    int          checked = 0;
    int          cyc = 0;
    int          lat, dir, ana, thr, pu, pud, n;

    always #5 pclk = ~pclk;

    sgp_gpio_port u_sgp_gpio_port (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .pad_schmitt_in(sch_in),
        .pad_ttl_in(ttl_in), .pad_out(pad_out), .pad_oe(pad_oe), .pad_pullup(pad_pu),
        .analog_enable(ana_en));
    sgp_pads u_sgp_pads (.pad_out(pad_out), .pad_oe(pad_oe), .ext_val(ext_val),
        .mid_lvl(mid_lvl), .pad_schmitt_in(sch_in), .pad_ttl_in(ttl_in));

    // Result checks
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp)
        begin
            err_count++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic cmp_pad(input logic [5:0] got, input logic [5:0] exp);
        checked++;
        if (got !== exp)
        begin
            err_count++;
            $display("ERROR t=%0t pad got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Bus transfer; no wait count assumed, the hang guard ends a stuck one
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] v,
                       input logic [3:0] s);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= v;
        pstrb <= s;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // Read every register and the pads against the model
    task automatic chk_all();
        int e[7];
        int dr;
        int oe;
        int lv;
        dr = (dir | 8) & 63;
        oe = ~dr & 63;
        lv = (oe & lat) | (~oe & ext_val);
        e = '{((thr & (lv | (mid_lvl & ~oe))) | (~thr & lv & ~(mid_lvl & ~oe))) & ~ana & 63,
              lat, dr, ana, thr, pu, pud << 7};
        repeat (4) @(posedge pclk);
        for (int i = 0; i < 7; i++)
        begin
            apb(1'b0, 12'(i * 4), 32'h0, 4'h0);
            cmp(rdat, e[i]);
        end
        #1;
        cmp_pad(pad_oe, oe);
        cmp_pad(pad_out, lat);
        cmp_pad(pad_pu, pud ? 0 : pu & dr);
        cmp_pad(ana_en, ana);
    endtask

    // Verdict
    task automatic summarize();
        $display("checks=%0d mismatches=%0d", checked, err_count);
        if (err_count == 0 && checked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    // Hang guard, far beyond the roughly 1600 cycles needed
    always @(posedge pclk)
    begin
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            err_count++;
            summarize();
        end
    end

    // Main sequence
    initial
    begin
        n = $urandom(5805);
        lat = 0;
        dir = 63;
        ana = 63;
        thr = 0;
        pu = 63;
        pud = 1;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        chk_all();
        $display("reset values done");
        for (n = 0; n < 16; n++)
        begin
            @(posedge pclk);
            ext_val <= 6'($urandom);
            mid_lvl <= 6'($urandom);
            lat = $urandom & 63;
            dir = $urandom & 63;
            ana = $urandom & 63;
            thr = $urandom & 63;
            pu = $urandom & 63;
            pud = $urandom & 1;
            apb(1'b1, 12'h004, lat, 4'hF);
            apb(1'b1, 12'h008, dir, 4'hF);
            apb(1'b1, 12'h00C, ana, 4'hF);
            apb(1'b1, 12'h010, thr, 4'hF);
            apb(1'b1, 12'h014, pu, 4'hF);
            apb(1'b1, 12'h018, pud << 7, 4'hF);
            chk_all();
            lat = $urandom & 63;
            apb(1'b1, 12'h000, lat, 4'h1);
            chk_all();
        end
        $display("random configurations done");
        apb(1'b1, 12'h01C, 32'hFFFFFFFF, 4'hF);
        cmp(rerr, 1);
        apb(1'b0, 12'h01C, 32'h0, 4'h0);
        cmp({rerr, rdat[30:0]}, 32'h80000000);
        apb(1'b1, 12'h004, ~lat, 4'h0);
        chk_all();
        $display("refusals done");
        summarize();
    end
endmodule
